// [dv/testbench.sv]
// Self-checking testbench of the counter array control block over AXI4-Lite.
`timescale 1ns/100ps
module testbench
   import cactl_pkg::*;
;
   logic           aclk;
   logic           aresetn;
   logic [31:0]    awaddr;
   logic           awvalid;
   logic           awready;
   logic [31:0]    wdata;
   logic [3:0]     wstrb;
   logic           wvalid;
   logic           wready;
   logic [1:0]     bresp;
   logic           bvalid;
   logic           bready;
   logic [31:0]    araddr;
   logic           arvalid;
   logic           arready;
   logic [31:0]    rdata;
   logic [1:0]     rresp;
   logic           rvalid;
   logic           rready;
   module_events_t ev;
   logic [15:0]    count;
   logic           irq;
   int             fail_count;
   int             checks_done;

   counter_array_control_flags counter_array_control_flags_inst (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .module_events(ev),
      .count(count), .irq(irq)
   );

   always #4 aclk = ~aclk;

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task test_done;
      $display("Comparisons %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : test_done

   task hang;
      fail_count++;
      $display("ERROR handshake expected answer seen none");
      test_done();
   endtask : hang

   // Both channels are offered together and released one by one as taken.
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            chk("bresp", {30'h0, bresp}, {30'h0, er});
            bready <= 1'b0;
            break;
         end
      end
      if (n == 50) hang();
      @(posedge aclk);
   endtask : wr

   task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            chk("rdata", rdata, ed);
            chk("rresp", {30'h0, rresp}, {30'h0, er});
            rready <= 1'b0;
            break;
         end
      end
      if (n == 50) hang();
      @(posedge aclk);
   endtask : rd

   task t_reset;
      rd(CTRL_OFFSET, 32'h0, RESP_OKAY);
      rd(STATUS_OFFSET, 32'h0, RESP_OKAY);
      rd(MASK_OFFSET, 32'h0, RESP_OKAY);
      rd(MODE_OFFSET, 32'h0, RESP_OKAY);
      rd(COUNT_OFFSET, 32'h0, RESP_OKAY);
      chk("irq", irq, 32'h0);
      rd(32'h0000_0040, 32'h0, RESP_SLVERR);
      wr(32'h0000_0040, 32'hff, RESP_SLVERR);
      wstrb <= 4'he;
      wr(MASK_OFFSET, 32'hff, RESP_OKAY);
      wstrb <= 4'hf;
      rd(MASK_OFFSET, 32'h0, RESP_OKAY);
   endtask : t_reset

   task automatic t_run;
      logic [15:0] c0;
      wr(CTRL_OFFSET, 32'h40, RESP_OKAY);
      rd(CTRL_OFFSET, 32'h40, RESP_OKAY);
      c0 = count;
      repeat (5) @(posedge aclk);
      chk("count running", {16'h0, count}, {16'h0, c0 + 16'h0005});
      wr(CTRL_OFFSET, 32'h0, RESP_OKAY);
      c0 = count;
      repeat (5) @(posedge aclk);
      chk("count halted", {16'h0, count}, {16'h0, c0});
   endtask : t_run

   task automatic t_ovf;
      int n;
      wr(MASK_OFFSET, 32'h80, RESP_OKAY);
      rd(MASK_OFFSET, 32'h80, RESP_OKAY);
      wr(CTRL_OFFSET, 32'h40, RESP_OKAY);
      for (n = 0; n < 70000; n++) begin
         @(posedge aclk);
         if (count === COUNT_MAX) break;
      end
      if (n == 70000) hang();
      chk("irq before wrap", irq, 32'h0);
      repeat (3) @(posedge aclk);
      chk("count after wrap", {16'h0, count}, 32'h2);
      chk("irq after wrap", irq, 32'h1);
      wr(CTRL_OFFSET, 32'h80, RESP_OKAY);
      repeat (10) @(posedge aclk);
      rd(CTRL_OFFSET, 32'h80, RESP_OKAY);
      wr(MASK_OFFSET, 32'h0, RESP_OKAY);
      chk("irq masked", irq, 32'h0);
      wr(MASK_OFFSET, 32'h80, RESP_OKAY);
      chk("irq unmasked", irq, 32'h1);
      wr(STATUS_OFFSET, 32'h0, RESP_OKAY);
      rd(CTRL_OFFSET, 32'h80, RESP_OKAY);
      wr(CTRL_OFFSET, 32'h0, RESP_OKAY);
      rd(STATUS_OFFSET, 32'h0, RESP_OKAY);
      chk("irq cleared", irq, 32'h0);
   endtask : t_ovf

   task automatic t_mod;
      int i;
      int k;
      wr(MASK_OFFSET, 32'h07, RESP_OKAY);
      for (i = 0; i < 3; i++) begin
         for (k = 0; k < 2; k++) begin
            if (k == 1) ev.capture <= 3'(1 << i);
            else ev.match <= 3'(1 << i);
            @(posedge aclk);
            ev.match   <= 3'h0;
            ev.capture <= 3'h0;
            repeat (2) @(posedge aclk);
            chk("irq module", irq, 32'h1);
            repeat (8) @(posedge aclk);
            rd(STATUS_OFFSET, 32'(1 << i), RESP_OKAY);
            rd(CTRL_OFFSET, 32'(1 << i), RESP_OKAY);
            if (k == 1) wr(STATUS_OFFSET, 32'(1 << i), RESP_OKAY);
            else wr(CTRL_OFFSET, 32'h0, RESP_OKAY);
            rd(STATUS_OFFSET, 32'h0, RESP_OKAY);
            chk("irq module cleared", irq, 32'h0);
         end
      end
      wr(MASK_OFFSET, 32'h06, RESP_OKAY);
      ev.match <= 3'h1;
      @(posedge aclk);
      ev.match <= 3'h0;
      repeat (3) @(posedge aclk);
      chk("irq module masked", irq, 32'h0);
      wr(MASK_OFFSET, 32'h01, RESP_OKAY);
      chk("irq module unmasked", irq, 32'h1);
      wr(STATUS_OFFSET, 32'h01, RESP_OKAY);
   endtask : t_mod

   task t_match_enable;
      wr(MODE_OFFSET, 32'h1, RESP_OKAY);
      ev.out_level <= 3'h2;
      repeat (3) @(posedge aclk);
      rd(STATUS_OFFSET, 32'h2, RESP_OKAY);
      ev.out_level <= 3'h0;
      wr(STATUS_OFFSET, 32'h2, RESP_OKAY);
      wr(MODE_OFFSET, 32'h0, RESP_OKAY);
      ev.out_level <= 3'h4;
      repeat (3) @(posedge aclk);
      rd(STATUS_OFFSET, 32'h0, RESP_OKAY);
      ev.out_level <= 3'h0;
      @(posedge aclk);
   endtask : t_match_enable

   initial begin
      aclk        = 1'b0;
      aresetn     = 1'b0;
      awaddr      = 32'h0;
      awvalid     = 1'b0;
      wdata       = 32'h0;
      wstrb       = 4'hf;
      wvalid      = 1'b0;
      bready      = 1'b0;
      araddr      = 32'h0;
      arvalid     = 1'b0;
      rready      = 1'b0;
      ev          = '0;
      fail_count  = 0;
      checks_done = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_run();
      t_ovf();
      t_mod();
      t_match_enable();
      test_done();
   end
endmodule : testbench

// [hdl/cactl_pkg.sv]
// Package with register map, field layout and bus types of the counter array control block.
package cactl_pkg;

   localparam logic [31:0] CTRL_OFFSET   = 32'h0000_0000;
   localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
   localparam logic [31:0] MASK_OFFSET   = 32'h0000_0008;
   localparam logic [31:0] MODE_OFFSET   = 32'h0000_000c;
   localparam logic [31:0] COUNT_OFFSET  = 32'h0000_0010;

   localparam int OVF_BIT   = 7;
   localparam int RUN_BIT   = 6;
   localparam int RSVD_HI   = 5;
   localparam int RSVD_LO   = 3;
   localparam int NUM_MOD   = 3;

   localparam logic [7:0]  CTRL_RESET  = 8'h00;
   localparam logic [7:0]  CTRL_RSVD_M = 8'h38;
   localparam logic [7:0]  FLAG_M      = 8'h87;
   localparam logic [15:0] COUNT_MAX   = 16'hffff;
   localparam logic [15:0] COUNT_ZERO  = 16'h0000;
   localparam logic [7:0]  IEN_RESET   = 8'h00;
   localparam logic [3:0]  MODE_RESET  = 4'h0;
   localparam int MODE_PWM16_BIT = 3;
   localparam int MATCH_EN_BIT   = 0;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic [NUM_MOD-1:0] match;
      logic [NUM_MOD-1:0] capture;
      logic [NUM_MOD-1:0] out_level;
   } module_events_t;

endpackage : cactl_pkg

// [hdl/counter16.sv]
// Sixteen-bit free counter gated by the run bit, with wrap pulse.
`timescale 1ns/100ps
module counter16
   import cactl_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        run_i,
   output logic [15:0]      count_q,
   output logic             wrap_o
);

   assign wrap_o = run_i && (count_q == COUNT_MAX);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_q <= COUNT_ZERO;
      end else if (run_i) begin
         count_q <= count_q + 16'h0001;
      end
   end

   property p_halt;
      @(posedge aclk) disable iff (!aresetn)
         !run_i |=> $stable(count_q);
   endproperty
   a_halt: assert property (p_halt) else $error("counter moved while halted");

   property p_wrap_zero;
      @(posedge aclk) disable iff (!aresetn)
         wrap_o |=> count_q == COUNT_ZERO;
   endproperty
   a_wrap_zero: assert property (p_wrap_zero) else $error("counter did not wrap to zero");

endmodule : counter16

// [hdl/counter_array_control_flags.sv]
// Control register, sticky flags, interrupt and AXI4-Lite slave of the counter array.
//
// Overview of operation
// - Overflow flag bit 7 sets when the counter wraps from all ones to zero.
// - A set overflow flag with its enable raises the array interrupt.
// - Overflow flag stays set until software writes it to zero. Here a one written to the status register clears it too.
// - Bit 6 runs the counter when one and halts it when zero.
// - Module flag bits 2..0 set on compare match or capture of that module.
// - A set module flag with its enable raises the array interrupt.
// - Module flags stay set until software clears them.
// - With match flag enable, a module flag also sets on output rising edge.
// - In 16-bit pulse mode the overflow flag marks the output falling edge. Here it sets only on the counter wrap, and MODE_PWM16_BIT is unused.
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
module counter_array_control_flags
   import cactl_pkg::*;
(
   input  wire logic           aclk,
   input  wire logic           aresetn,
   input  wire logic [31:0]    s_axi_awaddr,
   input  wire logic           s_axi_awvalid,
   output logic                s_axi_awready,
   input  wire logic [31:0]    s_axi_wdata,
   input  wire logic [3:0]     s_axi_wstrb,
   input  wire logic           s_axi_wvalid,
   output logic                s_axi_wready,
   output logic [1:0]          s_axi_bresp,
   output logic                s_axi_bvalid,
   input  wire logic           s_axi_bready,
   input  wire logic [31:0]    s_axi_araddr,
   input  wire logic           s_axi_arvalid,
   output logic                s_axi_arready,
   output logic [31:0]         s_axi_rdata,
   output logic [1:0]          s_axi_rresp,
   output logic                s_axi_rvalid,
   input  wire logic           s_axi_rready,
   input  wire module_events_t module_events,
   output logic [15:0]         count,
   output logic                irq
);

   logic                aw_held_q;
   logic [31:0]         awaddr_q;
   logic                w_held_q;
   logic [31:0]         wdata_q;
   logic [3:0]          wstrb_q;
   logic                wr_fire;
   logic                run_q;
   logic [7:0]          ien_q;
   logic [3:0]          mode_q;
   logic [NUM_MOD-1:0]  out_prev_q;
   logic [NUM_MOD-1:0]  mod_set;
   logic [NUM_MOD-1:0]  mod_clr;
   logic [NUM_MOD-1:0]  mod_flag;
   logic                ovf_flag;
   logic                ovf_clr;
   logic                wrap;
   logic [7:0]          ctrl_view;
   logic [7:0]          flags;
   logic                wr_ctrl;
   logic                wr_status;
   logic [31:0]         rdata_d;
   logic                rd_hit;

   // Write path: address and data are held separately, then fire together.
   assign s_axi_awready = !aw_held_q;
   assign s_axi_wready  = !w_held_q;
   assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         awaddr_q  <= 32'h0000_0000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_q <= 1'b1;
         awaddr_q  <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_q <= 1'b1;
         wdata_q  <= s_axi_wdata;
         wstrb_q  <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_q <= 1'b0;
      end
   end

   assign wr_ctrl   = wr_fire && wstrb_q[0] && (awaddr_q == CTRL_OFFSET);
   assign wr_status = wr_fire && wstrb_q[0] && (awaddr_q == STATUS_OFFSET);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (awaddr_q == CTRL_OFFSET || awaddr_q == STATUS_OFFSET ||
                          awaddr_q == MASK_OFFSET || awaddr_q == MODE_OFFSET ||
                          awaddr_q == COUNT_OFFSET) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control writes: the run bit is stored, reserved bits are discarded.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_q <= CTRL_RESET[RUN_BIT];
      end else if (wr_ctrl) begin
         run_q <= wdata_q[RUN_BIT];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ien_q  <= IEN_RESET;
         mode_q <= MODE_RESET;
      end else if (wr_fire && wstrb_q[0]) begin
         if (awaddr_q == MASK_OFFSET) begin
            ien_q <= wdata_q[7:0] & FLAG_M;
         end
         if (awaddr_q == MODE_OFFSET) begin
            mode_q <= wdata_q[3:0];
         end
      end
   end

   counter16 u_counter (
      .aclk    (aclk),
      .aresetn (aresetn),
      .run_i   (run_q),
      .count_q (count),
      .wrap_o  (wrap)
   );

   // A zero written to a flag clears it through the control register;
   // a one written to the status register clears it too.
   assign ovf_clr = (wr_ctrl && !wdata_q[OVF_BIT]) || (wr_status && wdata_q[OVF_BIT]);

   // Overflow sets only on the counter wrap; MODE_PWM16_BIT is not used.
   sticky_flag u_ovf (
      .aclk    (aclk),
      .aresetn (aresetn),
      .set_i   (wrap),
      .clr_i   (ovf_clr),
      .flag_q  (ovf_flag)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_prev_q <= '0;
      end else begin
         out_prev_q <= module_events.out_level;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_MOD; gi++) begin : g_mod
         assign mod_set[gi] = module_events.match[gi] || module_events.capture[gi] ||
                              (mode_q[MATCH_EN_BIT] && module_events.out_level[gi] &&
                               !out_prev_q[gi]);
         assign mod_clr[gi] = (wr_ctrl && !wdata_q[gi]) || (wr_status && wdata_q[gi]);
         sticky_flag u_flag (
            .aclk    (aclk),
            .aresetn (aresetn),
            .set_i   (mod_set[gi]),
            .clr_i   (mod_clr[gi]),
            .flag_q  (mod_flag[gi])
         );
      end
   endgenerate

   assign flags     = {ovf_flag, 4'h0, mod_flag};
   assign ctrl_view = {ovf_flag, run_q, 3'b000, mod_flag};
   assign irq       = |(flags & ien_q);

   // Read path.
   assign s_axi_arready = !s_axi_rvalid;

   always_comb begin
      rd_hit  = 1'b1;
      rdata_d = 32'h0000_0000;
      case (s_axi_araddr)
         CTRL_OFFSET:   rdata_d = {24'h000000, ctrl_view};
         STATUS_OFFSET: rdata_d = {24'h000000, flags};
         MASK_OFFSET:   rdata_d = {24'h000000, ien_q};
         MODE_OFFSET:   rdata_d = {28'h0000000, mode_q};
         COUNT_OFFSET:  rdata_d = {16'h0000, count};
         default:       rd_hit  = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rdata_d;
         s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   property p_irq_ovf;
      @(posedge aclk) disable iff (!aresetn)
         ovf_flag && ien_q[OVF_BIT] |-> irq;
   endproperty
   a_irq_ovf: assert property (p_irq_ovf) else $error("overflow irq missing");

   property p_irq_mod;
      @(posedge aclk) disable iff (!aresetn)
         mod_set[0] && ien_q[0] && !wr_fire |=> irq;
   endproperty
   a_irq_mod: assert property (p_irq_mod) else $error("module irq missing");

   property p_irq_quiet;
      @(posedge aclk) disable iff (!aresetn)
         !ovf_flag && (mod_flag == '0) |-> !irq;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("spurious irq");

   property p_rsvd_zero;
      @(posedge aclk) disable iff (!aresetn)
         s_axi_arvalid && s_axi_arready && (s_axi_araddr == CTRL_OFFSET) |=>
         (8'(s_axi_rdata) & CTRL_RSVD_M) == (CTRL_RESET & CTRL_RSVD_M);
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

   property p_run_write;
      @(posedge aclk) disable iff (!aresetn)
         wr_ctrl |=> run_q == $past(wdata_q[RUN_BIT]);
   endproperty
   a_run_write: assert property (p_run_write) else $error("run bit not stored");

   property p_wrap_flag;
      @(posedge aclk) disable iff (!aresetn)
         wrap |=> ovf_flag ##1 (ovf_flag || $past(ovf_clr));
   endproperty
   a_wrap_flag: assert property (p_wrap_flag) else $error("overflow flag not set");

   property p_uprise;
      @(posedge aclk) disable iff (!aresetn)
         mode_q[MATCH_EN_BIT] && module_events.out_level[1] && !out_prev_q[1] |=> mod_flag[1];
   endproperty
   a_uprise: assert property (p_uprise) else $error("up edge did not set flag");

   property p_mod_hold;
      @(posedge aclk) disable iff (!aresetn)
         mod_flag[2] && !mod_clr[2] |=> mod_flag[2];
   endproperty
   a_mod_hold: assert property (p_mod_hold) else $error("module flag self-cleared");

   property p_ovf_keep0;
      @(posedge aclk) disable iff (!aresetn)
         wr_status && !wdata_q[OVF_BIT] && ovf_flag |=> ovf_flag;
   endproperty
   a_ovf_keep0: assert property (p_ovf_keep0) else $error("zero cleared overflow");

   property p_ovf_keep1;
      @(posedge aclk) disable iff (!aresetn)
         wr_ctrl && wdata_q[OVF_BIT] && ovf_flag |=> ovf_flag;
   endproperty
   a_ovf_keep1: assert property (p_ovf_keep1) else $error("one cleared overflow");

   property p_ovf_clr0;
      @(posedge aclk) disable iff (!aresetn)
         wr_ctrl && !wdata_q[OVF_BIT] && !wrap |=> !ovf_flag;
   endproperty
   a_ovf_clr0: assert property (p_ovf_clr0) else $error("overflow not cleared");

   property p_mod_ev;
      @(posedge aclk) disable iff (!aresetn)
         module_events.match[2] || module_events.capture[2] |=> mod_flag[2];
   endproperty
   a_mod_ev: assert property (p_mod_ev) else $error("event did not set flag");

   property p_mod_w1c;
      @(posedge aclk) disable iff (!aresetn)
         wr_status && wdata_q[0] && !mod_set[0] |=> !mod_flag[0];
   endproperty
   a_mod_w1c: assert property (p_mod_w1c) else $error("flag not cleared");

   // Without the match enable an output up edge must leave the flag alone.
   property p_no_uprise;
      @(posedge aclk) disable iff (!aresetn)
         !mode_q[MATCH_EN_BIT] && !module_events.match[1] && !module_events.capture[1] &&
         !mod_flag[1] |=> !mod_flag[1];
   endproperty
   a_no_uprise: assert property (p_no_uprise) else $error("flag set without event");

   property p_irq_wrap;
      @(posedge aclk) disable iff (!aresetn)
         wrap && ien_q[OVF_BIT] && !wr_fire |=> irq;
   endproperty
   a_irq_wrap: assert property (p_irq_wrap) else $error("overflow irq late");

endmodule : counter_array_control_flags

// [hdl/sticky_flag.sv]
// One sticky event flag that hardware sets and software clears.
`timescale 1ns/100ps
module sticky_flag
   import cactl_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic set_i,
   input  wire logic clr_i,
   output logic      flag_q
);

   // A set in the same cycle as a clear wins, so no event is lost.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_q <= 1'b0;
      end else if (set_i) begin
         flag_q <= 1'b1;
      end else if (clr_i) begin
         flag_q <= 1'b0;
      end
   end

   property p_flag_holds;
      @(posedge aclk) disable iff (!aresetn)
         flag_q && !clr_i |=> flag_q;
   endproperty
   a_flag_holds: assert property (p_flag_holds) else $error("flag dropped without clear");

   property p_flag_sets;
      @(posedge aclk) disable iff (!aresetn)
         set_i |=> flag_q;
   endproperty
   a_flag_sets: assert property (p_flag_sets) else $error("flag not set after event");

endmodule : sticky_flag
